//--- pkg/uad_regs.svh
// register offsets, field positions and reset values of the
// attach/detach controller; the includer supplies the surrounding module.
`ifndef UAD_REGS_SVH
`define UAD_REGS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define UAD_OFF_CTRL 8'h00
`define UAD_OFF_PINSEL 8'h04
`define UAD_OFF_MAXPWR 8'h08
`define UAD_OFF_STATUS 8'h0C
`define UAD_OFF_IRQ_STAT 8'h10
`define UAD_OFF_IRQ_CLR 8'h14
`define UAD_OFF_IRQ_EN 8'h18

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define UAD_CTRL_RST 8'h00
`define UAD_PULLUP_PIN_RST 5'h00
`define UAD_SENSE_PIN_RST 5'h01
`define UAD_DETACH_PIN_RST 5'h02
`define UAD_WAKE_PIN_RST 5'h03
`define UAD_MAXPWR_RST_MA 10'h12C
`define UAD_MAXPWR_CAP_MA 10'h1F4

// ------------------------------------------------------------
// interrupt bit positions and width
// ------------------------------------------------------------
`define UAD_IRQ_W 6
`define UAD_IRQ_DETACH 0
`define UAD_IRQ_REATTACH 1
`define UAD_IRQ_PWR_LOST 2
`define UAD_IRQ_PWR_BACK 3
`define UAD_IRQ_SUSPEND 4
`define UAD_IRQ_RESUME 5

`endif

//--- pkg/uad_pkg.sv
// types shared by the attach/detach controller files.
// assumes the register header is included beside it.
package uad_pkg;

    // ------------------------------------------------------------
    // attach state and current budget
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        UAD_ST_OFF = 2'b00,
        UAD_ST_ATTACHED = 2'b01,
        UAD_ST_UNPLUGGED = 2'b10
    } uad_state_e;

    typedef enum logic [1:0] {
        UAD_BUD_SUSPEND = 2'b00,
        UAD_BUD_100MA = 2'b01,
        UAD_BUD_500MA = 2'b10
    } uad_budget_e;

    // ------------------------------------------------------------
    // software-visible configuration
    // ------------------------------------------------------------
    typedef struct packed {
        logic oob_enable;
        logic remote_wake;
        logic host_wake;
        logic configured;
        logic endpoint_audio;
        logic self_powered;
        logic ext_pullup;
        logic ready;
    } uad_ctrl_s;

    typedef struct packed {
        logic [4:0] wake_pin_select;
        logic [4:0] disconnect_pin_select;
        logic [4:0] power_sense_pin_select;
        logic [4:0] pullup_pin_select;
    } uad_pinsel_s;

endpackage

//--- hw/uad_sync.sv
// two-stage synchroniser for a bus of asynchronous levels.
// assumes one clock; the first stage feeds only the second.
`timescale 1ns/1ps
module uad_sync #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // two flops, reset low; a pin already high at reset still fires a rising-edge event two cycles later
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

//--- hw/uad_ctrl.sv
// usb attach/detach controller: d+ pull-up, bus power sense, out-of-band
// detach and host wake, suspend load gating and current budget.
// assumes a packet engine beside it that drives the data lines and reports
// suspend; pins arrive through the general i/o bus.
// Functional notes
// - full-speed peripheral only, never host
// - select wireless or audio endpoint set
// - pull-up on only when ready to enumerate
// - internal or external pull-up, internal default
// - self-powered: pull-up off without bus power
// - bus power sense pin selectable
// - 100 mA until configured, then 500
// - max power setting, default 300 mA
// - accept suspend; bus-powered radio off
// - switch off external loads in suspend
// - detach and wake pins each selectable
// - detach high: lines floating, pull-up off
// - detach low: reattach and await enumeration
// - host wake only while detach asserted
// - no in-band remote wake while detached
// - settle on full speed with any host
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "uad_regs.svh"
module uad_ctrl
    import uad_pkg::*;
#(
    parameter int N_PINS = 16
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic irq_out,
    // general i/o pins
    input wire logic [N_PINS-1:0] general_io_pin_in,
    output logic [N_PINS-1:0] general_io_pin_out,
    output logic [N_PINS-1:0] general_io_pin_oe_out,
    // packet engine side
    input wire logic eng_dp_in,
    input wire logic eng_dn_in,
    input wire logic eng_line_oe_in,
    input wire logic eng_suspend_in,
    output logic eng_full_speed_only_out,
    output logic eng_endpoint_audio_out,
    output logic [7:0] eng_max_power_out,
    output logic eng_remote_wake_out,
    // data lines
    output logic data_plus_line_out,
    output logic data_plus_line_oe_out,
    output logic data_minus_line_out,
    output logic data_minus_line_oe_out,
    output logic int_pullup_out,
    // power and loads
    output logic radio_enable_out,
    output logic load_enable_out,
    output logic [1:0] budget_out
);
    // ------------------------------------------------------------
    // registers and synchronised pins
    // ------------------------------------------------------------
    uad_ctrl_s ctrl_r;
    uad_pinsel_s pinsel_r;
    logic [9:0] maxpwr_r;
    logic [`UAD_IRQ_W-1:0] irq_stat_r;
    logic [`UAD_IRQ_W-1:0] irq_en_r;
    logic [`UAD_IRQ_W-1:0] irq_set;
    uad_state_e state_r;
    uad_state_e state_nxt;
    logic [N_PINS-1:0] pin_sync;
    logic det_now;
    logic vbus_now;
    logic det_prev_r;
    logic pok_prev_r;
    logic susp_prev_r;
    logic pwr_ok;
    logic suspended;
    logic ext_pull_on_r;
    logic host_wake_on_r;

    // pick one pin; a select past the pin count reads low
    function automatic logic pick_pin(input logic [N_PINS-1:0] bus, input logic [4:0] sel);
        logic v;
        v = 1'b0;
        for (int i = 0; i < N_PINS; i++) begin
            if (sel == 5'(i)) begin
                v = bus[i];
            end
        end
        return v;
    endfunction

    // whole pin bus synchronised before any select looks at it
    uad_sync #(
        .W(N_PINS)
    ) u_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in(general_io_pin_in),
        .sync_out(pin_sync)
    );

    // detach only counts when the out-of-band pins are in use
    assign det_now = ctrl_r.oob_enable && pick_pin(pin_sync, pinsel_r.disconnect_pin_select);
    assign vbus_now = pick_pin(pin_sync, pinsel_r.power_sense_pin_select);
    assign pwr_ok = !ctrl_r.self_powered || vbus_now;
    assign suspended = eng_suspend_in && (state_r == UAD_ST_ATTACHED);

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // writable configuration; internal pull-up after reset
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctrl_r <= uad_ctrl_s'(`UAD_CTRL_RST);
            pinsel_r <= {`UAD_WAKE_PIN_RST, `UAD_DETACH_PIN_RST, `UAD_SENSE_PIN_RST, `UAD_PULLUP_PIN_RST};
            maxpwr_r <= `UAD_MAXPWR_RST_MA;
            irq_en_r <= '0;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                `UAD_OFF_CTRL: ctrl_r <= reg_wdata_in[7:0];
                `UAD_OFF_PINSEL: begin
                    pinsel_r <= {reg_wdata_in[28:24], reg_wdata_in[20:16], reg_wdata_in[12:8], reg_wdata_in[4:0]};
                end
                `UAD_OFF_MAXPWR: maxpwr_r <= reg_wdata_in[9:0];
                `UAD_OFF_IRQ_EN: irq_en_r <= reg_wdata_in[`UAD_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // attach state machine
    // ------------------------------------------------------------
    // detach wins over everything; release drops to off, then reattaches
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            UAD_ST_OFF: begin
                if (det_now) begin
                    state_nxt = UAD_ST_UNPLUGGED;
                end else if (ctrl_r.ready && pwr_ok) begin
                    state_nxt = UAD_ST_ATTACHED;
                end
            end
            UAD_ST_ATTACHED: begin
                if (det_now) begin
                    state_nxt = UAD_ST_UNPLUGGED;
                end else if (!ctrl_r.ready || !pwr_ok) begin
                    state_nxt = UAD_ST_OFF;
                end
            end
            UAD_ST_UNPLUGGED: begin
                if (!det_now) begin
                    state_nxt = UAD_ST_OFF;
                end
            end
            default: state_nxt = UAD_ST_OFF;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_r <= UAD_ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // line drivers and pull-ups
    // ------------------------------------------------------------
    // outputs follow the next state so they line up with state_r
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            int_pullup_out <= 1'b0;
            ext_pull_on_r <= 1'b0;
            data_plus_line_out <= 1'b0;
            data_minus_line_out <= 1'b0;
            data_plus_line_oe_out <= 1'b0;
            data_minus_line_oe_out <= 1'b0;
        end else begin
            int_pullup_out <= (state_nxt == UAD_ST_ATTACHED) && !ctrl_r.ext_pullup;
            ext_pull_on_r <= (state_nxt == UAD_ST_ATTACHED) && ctrl_r.ext_pullup;
            data_plus_line_out <= eng_dp_in;
            data_minus_line_out <= eng_dn_in;
            // floating lines while unplugged, as if the cable were pulled
            data_plus_line_oe_out <= eng_line_oe_in && (state_nxt == UAD_ST_ATTACHED);
            data_minus_line_oe_out <= eng_line_oe_in && (state_nxt == UAD_ST_ATTACHED);
        end
    end

    // external pull-up and host wake share the general pin bus
    always_comb begin
        general_io_pin_out = '0;
        general_io_pin_oe_out = '0;
        for (int i = 0; i < N_PINS; i++) begin
            if (ctrl_r.ext_pullup && pinsel_r.pullup_pin_select == 5'(i)) begin
                general_io_pin_out[i] = ext_pull_on_r;
                general_io_pin_oe_out[i] = 1'b1;
            end else if (ctrl_r.oob_enable && pinsel_r.wake_pin_select == 5'(i)) begin
                general_io_pin_out[i] = host_wake_on_r;
                general_io_pin_oe_out[i] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // wake, suspend and power budget
    // ------------------------------------------------------------
    // out-of-band wake only when unplugged, in-band only when attached
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            host_wake_on_r <= 1'b0;
            eng_remote_wake_out <= 1'b0;
        end else begin
            host_wake_on_r <= ctrl_r.host_wake && (state_nxt == UAD_ST_UNPLUGGED);
            eng_remote_wake_out <= ctrl_r.remote_wake && (state_nxt == UAD_ST_ATTACHED);
        end
    end

    // self-powered boards keep the radio in suspend; loads go dark always
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            radio_enable_out <= 1'b0;
            load_enable_out <= 1'b0;
            budget_out <= UAD_BUD_100MA;
        end else begin
            radio_enable_out <= !(suspended && !ctrl_r.self_powered);
            load_enable_out <= !suspended;
            if (suspended) begin
                budget_out <= UAD_BUD_SUSPEND;
            end else if (ctrl_r.configured) begin
                budget_out <= UAD_BUD_500MA;
            end else begin
                budget_out <= UAD_BUD_100MA;
            end
        end
    end

    // descriptor counts 2 mA steps; capped at the 500 mA bus limit
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            eng_max_power_out <= 8'h00;
            eng_endpoint_audio_out <= 1'b0;
        end else begin
            if (maxpwr_r > `UAD_MAXPWR_CAP_MA) begin
                eng_max_power_out <= 8'(`UAD_MAXPWR_CAP_MA >> 1);
            end else begin
                eng_max_power_out <= maxpwr_r[8:1];
            end
            eng_endpoint_audio_out <= ctrl_r.endpoint_audio;
        end
    end

    // no high-speed chirp and no host role exist in this port
    assign eng_full_speed_only_out = 1'b1;

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            det_prev_r <= 1'b0;
            pok_prev_r <= 1'b0;
            susp_prev_r <= 1'b0;
        end else begin
            det_prev_r <= det_now;
            pok_prev_r <= vbus_now;
            susp_prev_r <= suspended;
        end
    end

    always_comb begin
        irq_set = '0;
        irq_set[`UAD_IRQ_DETACH] = det_now && !det_prev_r;
        irq_set[`UAD_IRQ_REATTACH] = !det_now && det_prev_r;
        irq_set[`UAD_IRQ_PWR_LOST] = !vbus_now && pok_prev_r;
        irq_set[`UAD_IRQ_PWR_BACK] = vbus_now && !pok_prev_r;
        irq_set[`UAD_IRQ_SUSPEND] = suspended && !susp_prev_r;
        irq_set[`UAD_IRQ_RESUME] = !suspended && susp_prev_r;
    end

    // a set in the clearing cycle survives the clear
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_stat_r <= '0;
        end else if (reg_wr_in && reg_addr_in == `UAD_OFF_IRQ_CLR) begin
            irq_stat_r <= (irq_stat_r & ~reg_wdata_in[`UAD_IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat_r <= irq_stat_r | irq_set;
        end
    end

    assign irq_out = |(irq_stat_r & irq_en_r);

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    // one cycle later; unmapped and write-only offsets read zero
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                `UAD_OFF_CTRL: reg_rdata_out <= {24'h000000, ctrl_r};
                `UAD_OFF_PINSEL: begin
                    reg_rdata_out <= {3'h0, pinsel_r.wake_pin_select, 3'h0, pinsel_r.disconnect_pin_select,
                                      3'h0, pinsel_r.power_sense_pin_select, 3'h0, pinsel_r.pullup_pin_select};
                end
                `UAD_OFF_MAXPWR: reg_rdata_out <= {22'h0, maxpwr_r};
                `UAD_OFF_STATUS: begin
                    reg_rdata_out <= {26'h0, suspended, vbus_now, det_now, 1'b0, state_r};
                end
                `UAD_OFF_IRQ_STAT: reg_rdata_out <= {26'h0, irq_stat_r};
                `UAD_OFF_IRQ_EN: reg_rdata_out <= {26'h0, irq_en_r};
                default: reg_rdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    logic pull_any;
    assign pull_any = int_pullup_out || ext_pull_on_r;

    sequence s_release_ready;
        $fell(det_now) && ctrl_r.ready && pwr_ok;
    endsequence

    sequence s_pins_steady;
        $stable(pinsel_r) [*3];
    endsequence

    property p_pull_needs_ready;
        !ctrl_r.ready |=> !pull_any;
    endproperty
    a_pull_needs_ready: assert property (p_pull_needs_ready) else $error("pull-up on while not ready");

    property p_internal_default;
        $rose(rst_n_in) |-> !ctrl_r.ext_pullup;
    endproperty
    a_internal_default: assert property (@(posedge clk_in) p_internal_default) else $error("external pull-up at reset");

    property p_no_power_no_pull;
        ctrl_r.self_powered && !vbus_now |=> !pull_any;
    endproperty
    a_no_power_no_pull: assert property (p_no_power_no_pull) else $error("pull-up without bus power");

    property p_detach_floats;
        det_now |=> !data_plus_line_oe_out && !data_minus_line_oe_out && !pull_any;
    endproperty
    a_detach_floats: assert property (p_detach_floats) else $error("lines driven while detached");

    property p_reattach;
        s_release_ready ##1 (!det_now && ctrl_r.ready && pwr_ok) |=> pull_any;
    endproperty
    a_reattach: assert property (p_reattach) else $error("no reattach after detach release");

    property p_wake_only_detached;
        host_wake_on_r |-> state_r == UAD_ST_UNPLUGGED;
    endproperty
    a_wake_only_detached: assert property (p_wake_only_detached) else $error("host wake while attached");

    property p_no_inband_wake;
        state_r != UAD_ST_ATTACHED |-> !eng_remote_wake_out;
    endproperty
    a_no_inband_wake: assert property (p_no_inband_wake) else $error("in-band wake while detached");

    property p_radio_suspend;
        suspended && !ctrl_r.self_powered |=> !radio_enable_out && !load_enable_out;
    endproperty
    a_radio_suspend: assert property (p_radio_suspend) else $error("radio or loads on in suspend");

    property p_budget;
        !ctrl_r.configured |=> budget_out != UAD_BUD_500MA;
    endproperty
    a_budget: assert property (p_budget) else $error("high budget before configuration");

    property p_sync_delay;
        s_pins_steady |-> det_now == (ctrl_r.oob_enable && $past(pick_pin(general_io_pin_in,
                                      pinsel_r.disconnect_pin_select), 2));
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("detach not two cycles behind pin");
endmodule

//--- bench/uad_host_model.sv
// far-side model: host or hub port plus the board around the pins.
// assumes open pins are pulled low and the hub holds d+ low through its pull-down.
`timescale 1ns/1ps
module uad_host_model #(
    parameter int N_PINS = 16,
    parameter int DET_PIN = 9,
    parameter int SENSE_PIN = 7,
    parameter int PU_PIN = 5
) (
    // device pin drive
    input wire logic [N_PINS-1:0] pin_out_in,
    input wire logic [N_PINS-1:0] pin_oe_in,
    input wire logic int_pullup_in,
    input wire logic full_speed_only_in,
    // board stimulus
    input wire logic detach_in,
    input wire logic vbus_in,
    // what the host and the pins see
    output logic [N_PINS-1:0] pin_level_out,
    output logic attach_seen_out,
    output logic full_speed_out
);
    // ------------------------------------------------------------
    // pin wire levels
    // ------------------------------------------------------------
    // driven pins show the device, detach and sense show the board, rest pulled low
    always_comb begin
        for (int i = 0; i < N_PINS; i++) begin
            if (pin_oe_in[i]) begin
                pin_level_out[i] = pin_out_in[i];
            end else if (i == DET_PIN) begin
                pin_level_out[i] = detach_in;
            end else if (i == SENSE_PIN) begin
                pin_level_out[i] = vbus_in;
            end else begin
                pin_level_out[i] = 1'b0;
            end
        end
    end

    // host sees attach on either pull-up; rate settles at full speed
    assign attach_seen_out = int_pullup_in | (pin_oe_in[PU_PIN] & pin_out_in[PU_PIN]);
    assign full_speed_out = full_speed_only_in;
endmodule

//--- bench/uad_ctrl_bench.sv
// self-checking bench for the attach/detach controller.
// assumes the register header on the include path and one 25 MHz clock.
`timescale 1ns/1ps
`include "uad_regs.svh"
module uad_ctrl_bench;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic susp = 1'b0;
    logic det = 1'b0;
    logic vbus = 1'b1;
    logic [31:0] d;
    int num_errors = 0;
    int comparisons = 0;
    wire [31:0] rdata;
    wire [15:0] pin_lvl, pin_out, pin_oe;
    wire [7:0] mpwr;
    wire [1:0] budget;
    wire irq, dp, dp_oe, dn, dn_oe, pu, fs, audio, rwake, radio, load, attach, host_fs;

    // clock at 40 ns period
    always #20 clk_in = ~clk_in;

    uad_ctrl dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .irq_out(irq),
        .general_io_pin_in(pin_lvl), .general_io_pin_out(pin_out), .general_io_pin_oe_out(pin_oe),
        .eng_dp_in(1'b1), .eng_dn_in(1'b0), .eng_line_oe_in(1'b1), .eng_suspend_in(susp),
        .eng_full_speed_only_out(fs), .eng_endpoint_audio_out(audio),
        .eng_max_power_out(mpwr), .eng_remote_wake_out(rwake),
        .data_plus_line_out(dp), .data_plus_line_oe_out(dp_oe),
        .data_minus_line_out(dn), .data_minus_line_oe_out(dn_oe), .int_pullup_out(pu),
        .radio_enable_out(radio), .load_enable_out(load), .budget_out(budget)
    );

    uad_host_model host (
        .pin_out_in(pin_out), .pin_oe_in(pin_oe), .int_pullup_in(pu), .full_speed_only_in(fs),
        .detach_in(det), .vbus_in(vbus),
        .pin_level_out(pin_lvl), .attach_seen_out(attach), .full_speed_out(host_fs)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask

    // read data appear at the edge after the strobe and hold until the next read, so sample just past that edge
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 d = rdata;
        chk(d & m, e, what);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // hang guard
    // ------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge clk_in);
        num_errors++;
        results();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        wait_cyc(3);
        chk(pu, 1'b0, "pull-up off before ready");
        chk(attach, 1'b0, "host sees no attach");
        chk(budget, 2'h1, "reset budget");
        chk({fs, host_fs}, 2'b11, "full speed only");
        chk(mpwr, 8'h96, "default max power");
        rchk(`UAD_OFF_CTRL, 32'hFFFF_FFFF, 32'h0, "ctrl reset, internal pull-up");
        rchk(`UAD_OFF_MAXPWR, 32'h3FF, 32'h12C, "max power reset");
        rchk(`UAD_OFF_PINSEL, 32'h1F1F_1F1F, 32'h0302_0100, "pin select reset");
        rchk(8'h1C, 32'hFFFF_FFFF, 32'h0, "unmapped read");
        wr_reg(`UAD_OFF_PINSEL, 32'h0B09_0705);
        rchk(`UAD_OFF_PINSEL, 32'h1F1F_1F1F, 32'h0B09_0705, "pin select");
        rchk(`UAD_OFF_IRQ_CLR, 32'hFFFF_FFFF, 32'h0, "write-only clear reads 0");
        wr_reg(`UAD_OFF_IRQ_EN, 32'h3F);
        // attach with internal pull-up, then configure
        wr_reg(`UAD_OFF_CTRL, 32'h01);
        wait_cyc(4);
        chk({pu, attach, dp_oe, dn_oe, dp, dn}, 6'b111110, "attached lines");
        rchk(`UAD_OFF_STATUS, 32'h13, 32'h11, "attached, power seen");
        chk(budget, 2'h1, "unconfigured budget");
        wr_reg(`UAD_OFF_CTRL, 32'h19);
        wait_cyc(4);
        chk({budget, audio}, 3'b101, "configured, audio set");
        wr_reg(`UAD_OFF_CTRL, 32'h11);
        wait_cyc(3);
        chk(audio, 1'b0, "transport set");
        // descriptor power: below and above the cap, then default
        wr_reg(`UAD_OFF_MAXPWR, 32'hC8);
        wait_cyc(3);
        chk(mpwr, 8'h64, "200 mA");
        wr_reg(`UAD_OFF_MAXPWR, 32'h258);
        wait_cyc(3);
        chk(mpwr, 8'hFA, "capped");
        rchk(`UAD_OFF_MAXPWR, 32'h3FF, 32'h258, "max power readback");
        wr_reg(`UAD_OFF_MAXPWR, 32'h12C);
        wait_cyc(3);
        chk(mpwr, 8'h96, "300 mA");
        // bus-powered suspend and resume
        @(posedge clk_in);
        susp <= 1'b1;
        wait_cyc(5);
        chk({radio, load, budget}, 4'b0000, "bus-powered suspend");
        rchk(`UAD_OFF_STATUS, 32'h20, 32'h20, "suspended flag");
        @(posedge clk_in);
        susp <= 1'b0;
        wait_cyc(5);
        chk({radio, load, budget}, 4'b1110, "resumed");
        rchk(`UAD_OFF_IRQ_STAT, 32'h30, 32'h30, "suspend and resume events");
        wr_reg(`UAD_OFF_IRQ_CLR, 32'h3F);
        rchk(`UAD_OFF_IRQ_STAT, 32'h3F, 32'h0, "events cleared");
        // self-powered with external pull-up, lose and regain bus power
        wr_reg(`UAD_OFF_CTRL, 32'h17);
        wait_cyc(4);
        chk({pu, pin_oe[5], pin_out[5], attach}, 4'b0111, "external pull-up");
        @(posedge clk_in);
        vbus <= 1'b0;
        wait_cyc(6);
        chk({pin_out[5], attach, dp_oe, irq}, 4'b0001, "power lost, pull-up off");
        rchk(`UAD_OFF_STATUS, 32'h13, 32'h00, "off without power");
        wr_reg(`UAD_OFF_IRQ_EN, 32'h00);
        wait_cyc(2);
        chk(irq, 1'b0, "masked event");
        rchk(`UAD_OFF_IRQ_STAT, 32'h04, 32'h04, "power lost sticky");
        wr_reg(`UAD_OFF_IRQ_CLR, 32'h3F);
        wr_reg(`UAD_OFF_IRQ_EN, 32'h3F);
        @(posedge clk_in);
        vbus <= 1'b1;
        wait_cyc(6);
        chk({pin_out[5], attach, irq}, 3'b111, "power back, reattached");
        wr_reg(`UAD_OFF_IRQ_CLR, 32'h3F);
        @(posedge clk_in);
        susp <= 1'b1;
        wait_cyc(5);
        chk({radio, load}, 2'b10, "self-powered suspend keeps radio");
        @(posedge clk_in);
        susp <= 1'b0;
        // out-of-band detach with remote wake enabled
        wr_reg(`UAD_OFF_CTRL, 32'hC1);
        wait_cyc(4);
        chk({pu, rwake, pin_oe[11], pin_out[11]}, 4'b1110, "attached, wake pin low");
        @(posedge clk_in);
        det <= 1'b1;
        wait_cyc(1);
        chk(pu, 1'b1, "detach not seen before sync");
        wait_cyc(4);
        chk({pu, attach, dp_oe, dn_oe, rwake}, 5'b00000, "detached, lines floating");
        rchk(`UAD_OFF_STATUS, 32'h0B, 32'h0A, "unplugged, detach seen");
        wr_reg(`UAD_OFF_CTRL, 32'hE1);
        wait_cyc(2);
        chk({pin_oe[11], pin_out[11]}, 2'b11, "host wake while detached");
        @(posedge clk_in);
        det <= 1'b0;
        wait_cyc(7);
        chk({pu, attach, dp_oe, pin_out[11], rwake}, 5'b11101, "reattached");
        rchk(`UAD_OFF_IRQ_STAT, 32'h03, 32'h03, "detach and reattach events");
        // detach input ignored without out-of-band enable
        wr_reg(`UAD_OFF_CTRL, 32'h01);
        @(posedge clk_in);
        det <= 1'b1;
        wait_cyc(6);
        chk({pu, dp_oe}, 2'b11, "detach ignored");
        @(posedge clk_in);
        det <= 1'b0;
        wait_cyc(3);
        results();
    end
endmodule
